// ### core/bus_mux_ctrl.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module bus_mux_ctrl #(
  parameter logic [6:0] own_address = 7'h40,
  parameter int unsigned long_cycles =
    mux_ctrl_pkg::TMO_LONG_US * 1000 / mux_ctrl_pkg::PCLK_PERIOD_NS,
  parameter int unsigned mid_cycles =
    mux_ctrl_pkg::TMO_MID_US * 1000 / mux_ctrl_pkg::PCLK_PERIOD_NS,
  parameter int unsigned short_cycles =
    mux_ctrl_pkg::TMO_SHORT_US * 1000 / mux_ctrl_pkg::PCLK_PERIOD_NS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply and enable
  input wire logic supply_lockout,
  input wire logic enable,
  input wire logic [3:0] downstream_fault_inputs_n,
  // Upstream bus
  input wire logic upstream_data_line_in,
  output logic upstream_data_line_out,
  output logic upstream_data_line_oe,
  input wire logic upstream_clock_line_in,
  output logic upstream_clock_line_out,
  output logic upstream_clock_line_oe,
  // Downstream buses, channel one in bit 0
  input wire logic [3:0] downstream_data_line_in,
  output logic [3:0] downstream_data_line_out,
  output logic [3:0] downstream_data_line_oe,
  input wire logic [3:0] downstream_clock_line_in,
  output logic [3:0] downstream_clock_line_out,
  output logic [3:0] downstream_clock_line_oe,
  // Alert, ready and accelerators
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic ready_out,
  output logic ready_oe,
  output logic upstream_boost,
  output logic [3:0] downstream_boost
);
  logic [15:0] syn; // Filtered pin levels
  logic [9:0] lanes; // Data lanes 0..4, clock lanes 5..9; lane 0/5 upstream
  logic [9:0] lanes_q; // Previous lane levels for edge finding
  logic lk; // Supply lockout active
  logic en_pin; // Enable input high
  logic run; // Commands accepted
  logic [3:0] fin_low; // Fault inputs asserted
  logic [3:0] logic_ok; // Channel idles with both lines high
  // Control state
  logic [3:0] sw;
  logic up_acc;
  logic dn_acc;
  logic ovr;
  logic [1:0] tsel;
  // Fault state
  logic conn_ok;
  logic [3:0] chan_ok;
  logic stk;
  logic stk_rt;
  logic pend_a;
  logic pend_b;
  logic [mux_ctrl_pkg::TMO_CNT_W-1:0] tmr;
  logic [mux_ctrl_pkg::TMO_CNT_W-1:0] limit;
  // Write path
  logic apb_wr;
  logic i2c_commit;
  logic wr_en;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic [3:0] next_sw;
  logic conn_wr;
  logic bad_conn;
  logic clr;
  logic node_low;
  logic hit;
  logic buf_act;
  logic new_a;
  logic rel;
  logic [7:0] rd_byte;
  // Wired-AND lanes
  logic [9:0] part;
  logic [9:0] src;
  logic [9:0] drv;
  logic [9:0] own;
  logic [2:0] blank [10];
  // Upstream 2-wire slave
  mux_ctrl_pkg::slv_state_t st;
  mux_ctrl_pkg::slv_state_t ack_next;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic slv_drv;
  logic pend_valid;
  logic [1:0] pend_idx;
  logic [7:0] pend_data;
  logic start_c;
  logic stop_c;
  logic srise;
  logic sfall;
  logic ara_hit;
  logic own_hit;

  // Every asynchronous pin through one synchroniser bank
  pin_sync #(
    .W(16),
    .INIT(mux_ctrl_pkg::SYNC_INIT)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({enable, supply_lockout, downstream_fault_inputs_n, downstream_clock_line_in,
      upstream_clock_line_in, downstream_data_line_in, upstream_data_line_in}),
    .level(syn)
  );

  assign lanes = syn[9:0];
  assign fin_low = ~syn[13:10];
  assign lk = syn[14];
  assign en_pin = syn[15];
  assign run = en_pin & ~lk;
  assign logic_ok = lanes[4:1] & lanes[9:6];

  // APB handshake; a 2-wire commit steals one cycle from APB
  assign pready = ~i2c_commit;
  assign pslverr = psel & penable & ((paddr[1:0] != 2'h0) | (paddr > mux_ctrl_pkg::OFF_SWITCH));
  assign apb_wr = psel & penable & pwrite & pready & ~pslverr;
  assign i2c_commit = run & stop_c & pend_valid;
  // Writes only land while enabled and powered
  assign wr_en = (apb_wr | i2c_commit) & run;
  assign wr_idx = apb_wr ? paddr[3:2] : pend_idx;
  assign wr_data = apb_wr ? pwdata[7:0] : pend_data;
  assign clr = wr_en & (wr_idx == mux_ctrl_pkg::IDX_FAULT);
  assign conn_wr = wr_en & (wr_idx == mux_ctrl_pkg::IDX_SWITCH);
  // Already-closed channels stay closed if written 1; others need a high idle state unless override is set
  assign next_sw = wr_data[7:4] & (ovr ? 4'hf : (logic_ok | sw));
  assign bad_conn = conn_wr & ~ovr & (|(wr_data[7:4] & ~sw & ~logic_ok));

  // Control bits; held at default while enable is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw <= mux_ctrl_pkg::SW_RESET;
      up_acc <= 1'b0;
      dn_acc <= 1'b0;
      ovr <= 1'b0;
      tsel <= mux_ctrl_pkg::TSEL_RESET;
    end
    else if (!run)
    begin
      sw <= mux_ctrl_pkg::SW_RESET;
      up_acc <= 1'b0;
      dn_acc <= 1'b0;
      ovr <= 1'b0;
      tsel <= mux_ctrl_pkg::TSEL_RESET;
    end
    else if (wr_en)
    begin
      // Switch bits survive a timeout; only writes, reset and the loss of run move them
      unique case (wr_idx)
        mux_ctrl_pkg::IDX_FAULT: ;
        mux_ctrl_pkg::IDX_ACCEL:
        begin
          up_acc <= wr_data[mux_ctrl_pkg::BIT_UP_ACCEL];
          dn_acc <= wr_data[mux_ctrl_pkg::BIT_DN_ACCEL];
        end
        mux_ctrl_pkg::IDX_CONFIG:
        begin
          ovr <= wr_data[mux_ctrl_pkg::BIT_OVERRIDE];
          tsel <= wr_data[1:0];
        end
        mux_ctrl_pkg::IDX_SWITCH: sw <= next_sw;
      endcase
    end
  end

  // Timeout length per select code
  always_comb
  begin
    unique case (tsel)
      mux_ctrl_pkg::TSEL_LONG: limit = mux_ctrl_pkg::TMO_CNT_W'(long_cycles);
      mux_ctrl_pkg::TSEL_MID: limit = mux_ctrl_pkg::TMO_CNT_W'(mid_cycles);
      mux_ctrl_pkg::TSEL_SHORT: limit = mux_ctrl_pkg::TMO_CNT_W'(short_cycles);
      mux_ctrl_pkg::TSEL_OFF: limit = '1;
    endcase
  end

  // Common switch nodes follow any closed channel line
  assign node_low = (|(sw & ~lanes[4:1])) | (|(sw & ~lanes[9:6]));
  assign hit = (tsel != mux_ctrl_pkg::TSEL_OFF) & (tmr == limit) & ~stk;
  assign stk_rt = node_low & (tsel != mux_ctrl_pkg::TSEL_OFF) & (tmr == limit);
  assign buf_act = run & (|sw) & ~stk;

  // Stuck-low timer, saturates at the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr <= '0;
    else if (!node_low || tsel == mux_ctrl_pkg::TSEL_OFF || clr)
      tmr <= '0;
    else if (tmr != limit)
      tmr <= tmr + 1'b1;
  end

  // Sticky faults; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conn_ok <= 1'b1;
      chan_ok <= mux_ctrl_pkg::CHAN_OK_RESET;
      stk <= 1'b0;
    end
    else
    begin
      if (bad_conn)
        conn_ok <= 1'b0;
      else if (clr)
        conn_ok <= 1'b1;
      chan_ok <= ~fin_low & (chan_ok | {4{clr}});
      if (hit)
        stk <= 1'b1;
      else if (clr)
        stk <= 1'b0;
    end
  end

  // First occurrence of a grouped fault; connected channels pass through
  assign new_a = bad_conn | (|(fin_low & chan_ok & ~(sw & {4{buf_act}})));

  // Alert pathways, released by response or direct addressing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end
    else
    begin
      if (new_a)
        pend_a <= 1'b1;
      else if (rel || clr)
        pend_a <= 1'b0;
      if (hit)
        pend_b <= 1'b1;
      else if (rel || clr)
        pend_b <= 1'b0;
    end
  end

  // Open-drain outputs; everything floats under lockout
  assign alert_n_out = 1'b0;
  assign ready_out = 1'b0;
  assign alert_n_oe = ~lk & (pend_a | pend_b | ((|(fin_low & sw)) & buf_act)
    | (~en_pin & (|fin_low)));
  assign ready_oe = ~lk & ~buf_act;

  // Participating lanes: upstream plus every closed channel
  assign part = buf_act ? {sw, 1'b1, sw, 1'b1} : 10'h000;
  assign own = drv | {9'h000, slv_drv};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_lane
      localparam int BASE = (gi / 5) * 5;
      logic other; // Another lane of the same line is held low from outside
      assign other = |(src[BASE+4:BASE] & ~(5'h01 << (gi % 5)));

      // Our own drive must not look like an outside low, hence the blanking
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          src[gi] <= 1'b0;
          drv[gi] <= 1'b0;
          blank[gi] <= 3'h0;
        end
        else
        begin
          src[gi] <= part[gi] & ~lanes[gi] & (src[gi] | (~own[gi] & (blank[gi] == 3'h0)));
          drv[gi] <= part[gi] & other;
          if (own[gi])
            blank[gi] <= mux_ctrl_pkg::BLANK_CYCLES;
          else if (blank[gi] != 3'h0)
            blank[gi] <= blank[gi] - 3'h1;
        end
      end
    end
  endgenerate

  assign upstream_data_line_out = 1'b0;
  assign upstream_clock_line_out = 1'b0;
  assign downstream_data_line_out = 4'h0;
  assign downstream_clock_line_out = 4'h0;
  assign upstream_data_line_oe = ~lk & own[0];
  assign upstream_clock_line_oe = ~lk & drv[5];
  assign downstream_data_line_oe = {4{~lk}} & drv[4:1];
  assign downstream_clock_line_oe = {4{~lk}} & drv[9:6];

  // Accelerator pulses on rising lane edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lanes_q <= 10'h3ff;
      upstream_boost <= 1'b0;
      downstream_boost <= 4'h0;
    end
    else
    begin
      lanes_q <= lanes;
      upstream_boost <= run & up_acc & ((lanes[0] & ~lanes_q[0]) | (lanes[5] & ~lanes_q[5]));
      downstream_boost <= {4{dn_acc}} & sw & ((lanes[4:1] & ~lanes_q[4:1])
        | (lanes[9:6] & ~lanes_q[9:6]));
    end
  end

  // Upstream bus conditions
  assign start_c = lanes_q[5] & lanes[5] & lanes_q[0] & ~lanes[0];
  assign stop_c = lanes_q[5] & lanes[5] & ~lanes_q[0] & lanes[0];
  assign srise = ~lanes_q[5] & lanes[5];
  assign sfall = lanes_q[5] & ~lanes[5];
  assign ara_hit = (shreg == {mux_ctrl_pkg::ARA_ADDR, 1'b1}) & (pend_a | pend_b);
  assign own_hit = shreg[7:1] == own_address;
  assign rel = run & sfall & (st == mux_ctrl_pkg::S_ADDR) & (bitcnt == 4'h8)
    & (ara_hit | own_hit);

  // Byte-level slave: write byte, alert response, address recognition
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= mux_ctrl_pkg::S_IDLE;
      ack_next <= mux_ctrl_pkg::S_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      slv_drv <= 1'b0;
      pend_valid <= 1'b0;
      pend_idx <= 2'h0;
      pend_data <= 8'h00;
    end
    else if (!run)
    begin
      st <= mux_ctrl_pkg::S_IDLE;
      slv_drv <= 1'b0;
      pend_valid <= 1'b0;
    end
    else if (start_c)
    begin
      st <= mux_ctrl_pkg::S_ADDR;
      bitcnt <= 4'h0;
      slv_drv <= 1'b0;
      pend_valid <= 1'b0;
    end
    else if (stop_c)
    begin
      st <= mux_ctrl_pkg::S_IDLE;
      slv_drv <= 1'b0;
      pend_valid <= 1'b0;
    end
    else if (srise && bitcnt != 4'h8 && (st == mux_ctrl_pkg::S_ADDR
      || st == mux_ctrl_pkg::S_CMD || st == mux_ctrl_pkg::S_DATA))
    begin
      shreg <= {shreg[6:0], lanes[0]};
      bitcnt <= bitcnt + 4'h1;
    end
    else if (sfall)
    begin
      unique case (st)
        mux_ctrl_pkg::S_ADDR:
          if (bitcnt == 4'h8)
          begin
            slv_drv <= ara_hit | own_hit;
            st <= (ara_hit | own_hit) ? mux_ctrl_pkg::S_ACK : mux_ctrl_pkg::S_WAIT;
            ack_next <= ara_hit ? mux_ctrl_pkg::S_TX
              : (shreg[0] ? mux_ctrl_pkg::S_WAIT : mux_ctrl_pkg::S_CMD);
          end
        mux_ctrl_pkg::S_CMD:
          if (bitcnt == 4'h8)
          begin
            pend_idx <= shreg[1:0];
            slv_drv <= 1'b1;
            st <= mux_ctrl_pkg::S_ACK;
            ack_next <= mux_ctrl_pkg::S_DATA;
          end
        mux_ctrl_pkg::S_DATA:
          if (bitcnt == 4'h8)
          begin
            pend_data <= shreg;
            pend_valid <= 1'b1;
            slv_drv <= 1'b1;
            st <= mux_ctrl_pkg::S_ACK;
            ack_next <= mux_ctrl_pkg::S_WAIT;
          end
        mux_ctrl_pkg::S_ACK:
        begin
          st <= ack_next;
          bitcnt <= 4'h0;
          slv_drv <= 1'b0;
          if (ack_next == mux_ctrl_pkg::S_TX)
          begin
            // First address bit goes out now, the rest shift from here
            slv_drv <= ~own_address[6];
            shreg <= {own_address[5:0], 2'b00};
            bitcnt <= 4'h1;
          end
        end
        mux_ctrl_pkg::S_TX:
          if (bitcnt == 4'h8)
          begin
            slv_drv <= 1'b0;
            st <= mux_ctrl_pkg::S_WAIT;
          end
          else
          begin
            slv_drv <= ~shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        mux_ctrl_pkg::S_IDLE, mux_ctrl_pkg::S_WAIT: ;
        default: st <= mux_ctrl_pkg::S_IDLE;
      endcase
    end
  end

  // Read view of the four registers
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (paddr[3:2])
      mux_ctrl_pkg::IDX_FAULT:
      begin
        rd_byte[3:0] = chan_ok;
        rd_byte[mux_ctrl_pkg::BIT_CONN_OK] = conn_ok;
        rd_byte[mux_ctrl_pkg::BIT_STK_LATCH] = stk;
        rd_byte[mux_ctrl_pkg::BIT_STK_RT] = stk_rt;
      end
      mux_ctrl_pkg::IDX_ACCEL:
      begin
        rd_byte[mux_ctrl_pkg::BIT_UP_ACCEL] = up_acc;
        rd_byte[mux_ctrl_pkg::BIT_DN_ACCEL] = dn_acc;
      end
      mux_ctrl_pkg::IDX_CONFIG:
      begin
        rd_byte[mux_ctrl_pkg::BIT_OVERRIDE] = ovr;
        rd_byte[1:0] = tsel;
      end
      mux_ctrl_pkg::IDX_SWITCH: rd_byte = {sw, logic_ok};
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= {24'h00_0000, rd_byte};
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_conn_low;
    conn_wr && !ovr && (|(wr_data[7:4] & ~sw & ~logic_ok));
  endsequence

  sequence s_timeout;
    !stk ##1 stk;
  endsequence

  chk_lockout_float: assert property (lk |-> !upstream_data_line_oe && !alert_n_oe
    && downstream_data_line_oe == 4'h0 && !ready_oe) else $error("pins driven in lockout");
  chk_enable_defaults: assert property (!en_pin |=> sw == 4'h0 && tsel == 2'h0 && !ovr)
    else $error("controls not defaulted");
  chk_enable_alert: assert property (!en_pin && !lk && |fin_low |-> alert_n_oe)
    else $error("fault input not on alert");
  chk_conn_select: assert property (conn_wr && !ovr |=> sw == $past(next_sw))
    else $error("wrong channels closed");
  chk_conn_fault: assert property (s_conn_low |=> !conn_ok && alert_n_oe)
    else $error("connection fault missed");
  chk_buf_gate: assert property (buf_act |-> |sw && !stk && ready_oe == lk)
    else $error("buffers on without cause");
  chk_boost_gate: assert property (|downstream_boost |-> |($past(sw) & downstream_boost))
    else $error("boost on open channel");
  chk_stuck_isolate: assert property (s_timeout |-> !buf_act && alert_n_oe
    && $stable(sw)) else $error("timeout did not isolate");
  chk_fault_clear: assert property (clr && !bad_conn && !hit |=> conn_ok && !stk)
    else $error("fault clear ignored");
  chk_repeat_discard: assert property (start_c && run |=> !pend_valid)
    else $error("write kept after repeated start");
endmodule : bus_mux_ctrl

// ### core/mux_ctrl_pkg.sv
package mux_ctrl_pkg;
  // Clock and timeout figures
  localparam int PCLK_PERIOD_NS = 100;
  localparam int TMO_LONG_US = 30000;
  localparam int TMO_MID_US = 15000;
  localparam int TMO_SHORT_US = 7500;
  localparam int TMO_CNT_W = 19;
  // Cycles a released lane is ignored while its synchroniser catches up
  localparam logic [2:0] BLANK_CYCLES = 3'h4;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_FAULT = 8'h00;
  localparam logic [7:0] OFF_ACCEL = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_SWITCH = 8'h0c;
  // Register indices, shared by APB word address and the 2-wire command byte
  localparam logic [1:0] IDX_FAULT = 2'h0;
  localparam logic [1:0] IDX_ACCEL = 2'h1;
  localparam logic [1:0] IDX_CONFIG = 2'h2;
  localparam logic [1:0] IDX_SWITCH = 2'h3;
  // Field positions
  localparam int BIT_CONN_OK = 7;
  localparam int BIT_STK_LATCH = 6;
  localparam int BIT_STK_RT = 5;
  localparam int BIT_UP_ACCEL = 7;
  localparam int BIT_DN_ACCEL = 6;
  localparam int BIT_OVERRIDE = 5;
  localparam int SW_LSB = 4;
  // Timeout select codes
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_LONG = 2'h1;
  localparam logic [1:0] TSEL_MID = 2'h2;
  localparam logic [1:0] TSEL_SHORT = 2'h3;
  // Values after reset
  localparam logic [3:0] SW_RESET = 4'h0;
  localparam logic [1:0] TSEL_RESET = 2'h0;
  localparam logic [3:0] CHAN_OK_RESET = 4'hf;
  // Sync reset: lanes idle high, lockout on, enable off
  localparam logic [15:0] SYNC_INIT = 16'h7fff;
  // Alert response address
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  // Upstream 2-wire slave states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_CMD = 3'b010,
    S_DATA = 3'b011,
    S_ACK = 3'b100,
    S_TX = 3'b101,
    S_WAIT = 3'b110
  } slv_state_t;
endpackage : mux_ctrl_pkg

// ### core/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] ff1; // Metastability catcher, read by ff2 only
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ff1 <= INIT;
      ff2 <= INIT;
      ff3 <= INIT;
      level <= INIT;
    end
    else
    begin
      ff1 <= raw;
      ff2 <= ff1;
      ff3 <= ff2;
      level <= (ff2 & ~(ff2 ^ ff3)) | (level & (ff2 ^ ff3));
    end
  end
endmodule : pin_sync

// ### dv/bus_far_side.sv
`timescale 1ns/100ps
module bus_far_side (
  // Device pull-down enables
  input wire logic up_sda_oe,
  input wire logic up_scl_oe,
  input wire logic [3:0] dn_sda_oe,
  input wire logic [3:0] dn_scl_oe,
  // Master clock and data, slave data pull-downs
  input wire logic mst_scl_low,
  input wire logic mst_sda_low,
  input wire logic [3:0] slv_sda_low,
  // Resolved wire levels
  output logic up_sda,
  output logic up_scl,
  output logic [3:0] dn_sda,
  output logic [3:0] dn_scl
);
  // Pulled-up wires: low while any party drives
  assign up_sda = ~(up_sda_oe | mst_sda_low);
  assign up_scl = ~(up_scl_oe | mst_scl_low);
  assign dn_sda = ~(dn_sda_oe | slv_sda_low);
  assign dn_scl = ~dn_scl_oe;
endmodule : bus_far_side

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // Bus and pin stimulus
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic lockout = 0, enable = 1, mst_low = 0, mst_dlow = 0, err, ack;
  // Device address on the 2-wire link, arbitrary
  localparam logic [6:0] own = 7'h40;
  wire [11:0] outs; // Open-drain output levels of the line, alert and ready pins, must stay low
  logic [7:0] paddr = 8'h00, rd, sw;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] flt_n = 4'hf, slv_low = 4'h0;
  // Design outputs and resolved wires
  logic pready, pslverr, up_d, up_c, up_doe, up_coe, al_oe, rdy_oe, up_bst;
  logic [3:0] dn_d, dn_c, dn_doe, dn_coe, dn_bst;
  int error_cnt = 0, n_tests = 0, seed = 23, nb_up = 0, nb_dn = 0, nb_off = 0;

  // Short timeouts keep the stuck scenario brief
  bus_mux_ctrl #(.own_address(own), .long_cycles(40), .mid_cycles(20), .short_cycles(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_lockout(lockout), .enable(enable), .downstream_fault_inputs_n(flt_n),
    .upstream_data_line_in(up_d), .upstream_data_line_out(outs[0]),
    .upstream_data_line_oe(up_doe), .upstream_clock_line_in(up_c),
    .upstream_clock_line_out(outs[1]), .upstream_clock_line_oe(up_coe),
    .downstream_data_line_in(dn_d), .downstream_data_line_out(outs[5:2]),
    .downstream_data_line_oe(dn_doe), .downstream_clock_line_in(dn_c),
    .downstream_clock_line_out(outs[9:6]), .downstream_clock_line_oe(dn_coe),
    .alert_n_out(outs[10]), .alert_n_oe(al_oe), .ready_out(outs[11]), .ready_oe(rdy_oe),
    .upstream_boost(up_bst), .downstream_boost(dn_bst));

  bus_far_side far (.up_sda_oe(up_doe), .up_scl_oe(up_coe), .dn_sda_oe(dn_doe),
    .dn_scl_oe(dn_coe), .mst_scl_low(mst_low), .mst_sda_low(mst_dlow),
    .slv_sda_low(slv_low), .up_sda(up_d),
    .up_scl(up_c), .dn_sda(dn_d), .dn_scl(dn_c));

  // Clock, boost pulse counters, watchdog
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    nb_up <= nb_up + up_bst;
    nb_dn <= nb_dn + dn_bst[0];
    nb_off <= nb_off + (dn_bst[3:1] != 3'h0);
  end
  initial
  begin
    #3_000_000;
    error_cnt++;
    results;
  end

  task results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One link bit; the slave answers some cycles after a synced fall, so low is long
  task i2c_bit(input logic b, output logic s);
    mst_low <= 1'b1;
    repeat (2) @(posedge pclk);
    mst_dlow <= ~b;
    repeat (4) @(posedge pclk);
    mst_low <= 1'b0;
    repeat (2) @(posedge pclk);
    s = up_d;
  endtask : i2c_bit

  // Byte MSB first, then the acknowledge slot, which must read low
  task i2c_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], s);
    i2c_bit(1'b1, s);
    chk(s, 0, "no ack");
  endtask : i2c_byte

  // Reset with pins idle; synchronisers need a few edges after
  task rst;
    presetn <= 1'b0;
    enable <= 1'b1;
    lockout <= 1'b0;
    flt_n <= 4'hf;
    slv_low <= 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : rst

  // Master clock burst at the link period
  task burst;
    repeat (4)
    begin
      mst_low <= 1'b1;
      repeat (4) @(posedge pclk);
      mst_low <= 1'b0;
      // Synchroniser plus two cycles of lane logic (src, then drv) before the copy appears
      repeat (3) @(posedge pclk);
      chk(dn_coe[0], 1, "scl follow");
      @(posedge pclk);
    end
  endtask : burst

  initial
  begin
    int u0, d0;
    rst;
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd, 8'h8f, "fault rst");
    chk(rdy_oe, 1, "ready rst");
    apb(0, 8'h10, 0);
    chk(err, 1, "unmapped");
    // Corner and random channel sets
    for (int i = 0; i < 8; i++)
    begin
      sw = (i == 0) ? 8'h00 : (i == 1) ? 8'h0f : 8'($random(seed));
      apb(1, mux_ctrl_pkg::OFF_SWITCH, {sw[3:0], 4'h0});
      apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
      chk(rd[7:4], sw[3:0], "conn");
      chk(rdy_oe, sw[3:0] == 4'h0, "ready");
    end
    // Enable low: defaults, writes ignored, faults still alert
    enable <= 1'b0;
    flt_n <= 4'hb;
    repeat (8) @(posedge pclk);
    apb(1, mux_ctrl_pkg::OFF_SWITCH, 8'hf0);
    chk(al_oe, 1, "alert en low");
    enable <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
    chk(rd[7:4], 0, "en low sw");
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd, 8'h8b, "chan fault");
    flt_n <= 4'hf;
    repeat (8) @(posedge pclk);
    apb(1, mux_ctrl_pkg::OFF_FAULT, 8'h5a);
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd, 8'h8f, "clear");
    chk(al_oe, 0, "alert clr");
    // Connect with channel two idling low
    slv_low <= 4'h2;
    repeat (8) @(posedge pclk);
    apb(1, mux_ctrl_pkg::OFF_SWITCH, 8'hf0);
    apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
    chk(rd[7:4], 4'hd, "skip low");
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd, 8'h0f, "conn fault");
    chk(al_oe, 1, "conn alert");
    apb(1, mux_ctrl_pkg::OFF_FAULT, 8'h00);
    apb(1, mux_ctrl_pkg::OFF_CONFIG, 8'h20);
    apb(1, mux_ctrl_pkg::OFF_SWITCH, 8'hf0);
    apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
    chk(rd[7:4], 4'hf, "override");
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd[7], 1, "no conn fault");
    // Stuck low on closed channel one
    rst;
    apb(1, mux_ctrl_pkg::OFF_CONFIG, {6'h00, mux_ctrl_pkg::TSEL_SHORT});
    apb(1, mux_ctrl_pkg::OFF_SWITCH, 8'h10);
    slv_low <= 4'h1;
    repeat (7) @(posedge pclk);
    chk(up_doe, 1, "wired and");
    chk(|outs, 0, "drive level");
    chk(al_oe, 0, "early");
    repeat (20) @(posedge pclk);
    chk(al_oe, 1, "stuck alert");
    chk(up_doe, 0, "isolated");
    apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
    chk(rd[7:4], 4'h1, "sw kept");
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd[6:5], 2'h3, "stuck bits");
    slv_low <= 4'h0;
    repeat (8) @(posedge pclk);
    apb(0, mux_ctrl_pkg::OFF_FAULT, 0);
    chk(rd[6:5], 2'h2, "stuck rt");
    lockout <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({5'h00, al_oe, up_doe, up_coe}, 0, "lockout");
    chk({dn_doe, dn_coe}, 0, "lockout dn");
    // Accelerators across a link clock burst
    rst;
    apb(1, mux_ctrl_pkg::OFF_SWITCH, 8'h10);
    u0 = nb_up;
    burst;
    chk(nb_up != u0, 0, "boost off");
    apb(1, mux_ctrl_pkg::OFF_ACCEL, 8'hc0);
    u0 = nb_up;
    d0 = nb_dn;
    burst;
    chk(nb_up > u0, 1, "up boost");
    chk(nb_dn > d0, 1, "dn boost");
    chk(nb_off != 0, 0, "open boost");
    // Pending alert, then a 2-wire write to our own address
    rst;
    flt_n <= 4'he;
    repeat (8) @(posedge pclk);
    flt_n <= 4'hf;
    repeat (8) @(posedge pclk);
    chk(al_oe, 1, "pending");
    mst_dlow <= 1'b1;
    repeat (4) @(posedge pclk);
    i2c_byte({own, 1'b0});
    chk(al_oe, 0, "addressed");
    i2c_byte(8'h03);
    i2c_byte(8'h30);
    // Stop: data rises while the clock stands high
    i2c_bit(1'b0, ack);
    mst_dlow <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(0, mux_ctrl_pkg::OFF_SWITCH, 0);
    chk(rd[7:4], 4'h3, "link write");
    results;
  end
endmodule : tb_top
